//--- inc/panel_cfg.svh
`ifndef PANEL_CFG_SVH
`define PANEL_CFG_SVH

// timing, in milliseconds at a 40 kHz clock
`define PNL_CLK_KHZ    40
`define PNL_DEB_MS     10
`define PNL_HOLD_MS    1000
`define PNL_RATE_MS    100
`define PNL_BLINK_MS   500
`define PNL_FLICK_MS   250
`define PNL_MS2CYC(ms) ((ms) * `PNL_CLK_KHZ)

// keys
`define PNL_NKEYS      6
`define PNL_KEY_SEL    0
`define PNL_KEY_UP     1
`define PNL_KEY_DOWN   2
`define PNL_KEY_TEST   3
`define PNL_KEY_ACK    4
`define PNL_KEY_EXT    5
`define PNL_NITEMS     4

// register byte offsets
`define PNL_OFS_CTRL   8'h00
`define PNL_OFS_STAT   8'h04
`define PNL_OFS_SETV   8'h10
`define PNL_OFS_ISTAT  8'h30
`define PNL_OFS_ICLR   8'h34
`define PNL_OFS_IEN    8'h38

// field positions
`define PNL_CTRL_STBY  0
`define PNL_IRQ_KEY    0
`define PNL_IRQ_ALARM  1
`define PNL_IRQ_FAULT  2

// reset values of the setting items
`define PNL_RST_SET0   8'h14
`define PNL_RST_SET1   8'h28
`define PNL_RST_SET2   8'h3C
`define PNL_RST_SET3   8'h05

`endif

//--- inc/panel_pkg.sv
package panel_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'b00,
        MODE_SETTING = 2'b01,
        MODE_TEST    = 2'b10
    } panel_mode_e;

    typedef logic [7:0] value_t;

endpackage

//--- inc/key_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "panel_cfg.svh"
interface key_if;
    logic [`PNL_NKEYS-1:0] press;
    logic [`PNL_NKEYS-1:0] held;
    modport src (output press, output held);
    modport dst (input press, input held);
endinterface
`default_nettype wire

//--- verilog/key_debounce.sv
`timescale 1ns/1ps
`default_nettype none
`include "panel_cfg.svh"
module key_debounce
#(
    parameter int DEB_CYC = `PNL_MS2CYC(`PNL_DEB_MS)
)
(
    // clock and control
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  ce_i,
    // raw keys, active low
    input  wire logic [`PNL_NKEYS-1:0] keys_n_i,
    // filtered keys
    key_if.src                         keys
);
    localparam int CW = $clog2(DEB_CYC + 1);

    genvar i;
    generate
        for (i = 0; i < `PNL_NKEYS; i++)
        begin : g_key
            logic          s1;
            logic          s2;
            logic          lvl;
            logic          prs;
            logic [CW-1:0] cnt;

            // two-flop synchroniser
            always_ff @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    s1 <= 1'b1;
                    s2 <= 1'b1;
                end
                else if (ce_i)
                begin
                    s1 <= keys_n_i[i];
                    s2 <= s1;
                end
            end

            always_ff @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    cnt <= '0;
                    lvl <= 1'b0;
                    prs <= 1'b0;
                end
                else if (ce_i)
                begin
                    prs <= 1'b0;
                    if (!s2 == lvl)
                        cnt <= '0;
                    else if (cnt == CW'(DEB_CYC - 1))
                    begin
                        cnt <= '0;
                        lvl <= !s2;
                        prs <= !s2;     // pulse on the accepted press only
                    end
                    else
                        cnt <= cnt + 1'b1;
                end
            end

            assign keys.press[i] = prs;
            assign keys.held[i]  = lvl;
        end
    endgenerate
endmodule
`default_nettype wire

//--- verilog/step_repeat.sv
`timescale 1ns/1ps
`default_nettype none
module step_repeat
#(
    parameter int HOLD_CYC = 40000000,
    parameter int RATE_CYC = 4000000
)
(
    // clock and control
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    // filtered key
    input  wire logic press_i,
    input  wire logic held_i,
    // one step per press, then repeated steps
    output logic      step_o
);
    localparam int CW = $clog2(HOLD_CYC + 1);

    logic [CW-1:0] cnt;
    logic          fast;
    logic          rep;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt  <= '0;
            fast <= 1'b0;
            rep  <= 1'b0;
        end
        else if (ce_i)
        begin
            rep <= 1'b0;
            if (!held_i)
            begin
                cnt  <= '0;
                fast <= 1'b0;
            end
            else if ((!fast && cnt == CW'(HOLD_CYC - 1)) || (fast && cnt == CW'(RATE_CYC - 1)))
            begin
                cnt  <= '0;
                fast <= 1'b1;
                rep  <= 1'b1;
            end
            else
                cnt <= cnt + 1'b1;
        end
    end

    assign step_o = press_i | rep;
endmodule
`default_nettype wire

//--- verilog/panel_ctrl.sv
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "panel_cfg.svh"
module panel_ctrl
    import panel_pkg::*;
#(
    parameter int DEB_CYC   = `PNL_MS2CYC(`PNL_DEB_MS),
    parameter int HOLD_CYC  = `PNL_MS2CYC(`PNL_HOLD_MS),
    parameter int RATE_CYC  = `PNL_MS2CYC(`PNL_RATE_MS),
    parameter int BLINK_CYC = `PNL_MS2CYC(`PNL_BLINK_MS),
    parameter int FLICK_CYC = `PNL_MS2CYC(`PNL_FLICK_MS)
)
(
    // clock, reset, enable
    input  wire logic                  REF_CLK_I,
    input  wire logic                  RST_N_I,
    input  wire logic                  CE_I,
    // avalon-mm slave
    input  wire logic [7:0]            AVS_ADDRESS_I,
    input  wire logic                  AVS_READ_I,
    input  wire logic                  AVS_WRITE_I,
    input  wire logic [31:0]           AVS_WRITEDATA_I,
    input  wire logic [3:0]            AVS_BYTEENABLE_I,
    output logic      [31:0]           AVS_READDATA_O,
    output logic                       AVS_WAITREQUEST_O,
    output logic                       IRQ_O,
    // front panel keys and reset contact, active low
    input  wire logic [`PNL_NKEYS-1:0] KEYS_N_I,
    // measurement side
    input  wire logic [2:0]            ALARM_LVL_I,
    input  wire logic                  FAULT_I,
    // indicators
    output logic                       STANDBY_LED_O,
    output logic      [2:0]            ALARM_LED_O,
    output logic                       TROUBLE_LED_O,
    output logic                       BUZZER_O,
    output logic                       DISP_BLANK_O,
    // state seen by the display driver
    output logic      [1:0]            MODE_O,
    output logic      [7:0]            TEST_VALUE_O
);
    localparam int BW = $clog2(BLINK_CYC + 1);
    localparam int FW = $clog2(FLICK_CYC + 1);

    key_if keys ();

    panel_mode_e mode;
    logic [1:0]  item;
    value_t      setv [`PNL_NITEMS];
    value_t      test_val;
    value_t      sel_val;
    logic [2:0]  step;
    logic        clr;
    logic        ack;
    logic        req;
    logic        wr_en;
    logic        ctrl_stby;
    logic [2:0]  alarm_lat;
    logic [2:0]  test_lvl;
    logic [2:0]  lvl_prev;
    logic        fault_prev;
    logic        ev_alarm;
    logic        ev_fault;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_en;
    logic [2:0]  irq_ev;
    logic [BW-1:0] blink_cnt;
    logic [FW-1:0] flick_cnt;

    // matches one of the setting value words
    function automatic logic is_setv(input logic [7:0] a);
        return (a[7:4] == 4'(`PNL_OFS_SETV >> 4)) && (a[1:0] == 2'b00);
    endfunction

    key_debounce #(
        .DEB_CYC (DEB_CYC)
    ) u_deb (
        .clk_i    (REF_CLK_I),
        .rst_n_i  (RST_N_I),
        .ce_i     (CE_I),
        .keys_n_i (KEYS_N_I),
        .keys     (keys.src)
    );

    // up, down and test keys get press plus hold repeat
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_rep
            step_repeat #(
                .HOLD_CYC (HOLD_CYC),
                .RATE_CYC (RATE_CYC)
            ) u_rep (
                .clk_i   (REF_CLK_I),
                .rst_n_i (RST_N_I),
                .ce_i    (CE_I),
                .press_i (keys.press[`PNL_KEY_UP + g]),
                .held_i  (keys.held[`PNL_KEY_UP + g]),
                .step_o  (step[g])
            );
        end
    endgenerate

    // external contact shares the acknowledge path
    assign clr = keys.press[`PNL_KEY_ACK] | keys.press[`PNL_KEY_EXT];

    // bus handshake: one wait cycle, answer on the second
    assign req               = AVS_READ_I | AVS_WRITE_I;
    assign AVS_WAITREQUEST_O = req & ~(ack & CE_I);
    assign wr_en             = AVS_WRITE_I & ack & AVS_BYTEENABLE_I[0];
    assign sel_val           = setv[item];

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            ack <= 1'b0;
        else if (CE_I)
            ack <= req & ~ack;
    end

    // read data captured in the wait cycle
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            AVS_READDATA_O <= '0;
        else if (CE_I && AVS_READ_I && !ack)
        begin
            AVS_READDATA_O <= '0;
            if (is_setv(AVS_ADDRESS_I))
                AVS_READDATA_O[7:0] <= setv[AVS_ADDRESS_I[3:2]];
            else
                case (AVS_ADDRESS_I)
                    `PNL_OFS_CTRL:  AVS_READDATA_O[0] <= ctrl_stby;
                    `PNL_OFS_STAT:  AVS_READDATA_O[15:0] <=
                        {test_val, BUZZER_O, alarm_lat, item, mode};
                    `PNL_OFS_ISTAT: AVS_READDATA_O[2:0] <= irq_stat;
                    `PNL_OFS_IEN:   AVS_READDATA_O[2:0] <= irq_en;
                    default:        AVS_READDATA_O <= '0;
                endcase
        end
    end

    // control register
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            ctrl_stby <= 1'b0;
        else if (CE_I && wr_en && AVS_ADDRESS_I == `PNL_OFS_CTRL)
            ctrl_stby <= AVS_WRITEDATA_I[`PNL_CTRL_STBY];
    end

    // operating mode
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            mode <= MODE_NORMAL;
        else if (CE_I)
        begin
            case (mode)
                MODE_NORMAL:
                begin
                    if (keys.press[`PNL_KEY_SEL])
                        mode <= MODE_SETTING;
                    else if (keys.press[`PNL_KEY_TEST])
                        mode <= MODE_TEST;
                end
                MODE_SETTING:
                begin
                    if (clr)
                        mode <= MODE_NORMAL;
                end
                MODE_TEST:
                begin
                    if (clr)
                        mode <= MODE_NORMAL;
                end
                default: mode <= MODE_NORMAL;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            item <= 2'h0;
        else if (CE_I)
        begin
            if (mode != MODE_SETTING || clr)
                item <= 2'h0;
            else if (keys.press[`PNL_KEY_SEL])
                item <= item + 2'h1;
        end
    end

    // setting values: bus writes win over key steps
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            setv[0] <= `PNL_RST_SET0;
            setv[1] <= `PNL_RST_SET1;
            setv[2] <= `PNL_RST_SET2;
            setv[3] <= `PNL_RST_SET3;
        end
        else if (CE_I)
        begin
            if (wr_en && is_setv(AVS_ADDRESS_I))
                setv[AVS_ADDRESS_I[3:2]] <= AVS_WRITEDATA_I[7:0];
            else if (mode == MODE_SETTING && !clr)
            begin
                if (step[0] && !step[1] && sel_val != 8'hFF)
                    setv[item] <= sel_val + 8'h01;
                else if (step[1] && !step[0] && sel_val != 8'h00)
                    setv[item] <= sel_val - 8'h01;
            end
        end
    end

    // simulated value stepped by the test key
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            test_val <= 8'h00;
        else if (CE_I)
        begin
            if (mode != MODE_TEST)
                test_val <= 8'h00;
            else if (step[2])
                test_val <= test_val + 8'h01;
        end
    end

    // test value against the level thresholds
    always_comb
    begin
        for (int k = 0; k < 3; k++)
            test_lvl[k] = (mode == MODE_TEST) && (test_val >= setv[k]);
    end

    // latched alarms, a new alarm wins over the clear
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            alarm_lat <= 3'h0;
        else if (CE_I)
            alarm_lat <= (alarm_lat & ~{3{clr}}) | ALARM_LVL_I;
    end

    // lamps from latched alarms or test value, trouble lamp from live fault
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            ALARM_LED_O   <= 3'h0;
            TROUBLE_LED_O <= 1'b0;
        end
        else if (CE_I)
        begin
            ALARM_LED_O   <= alarm_lat | test_lvl;
            TROUBLE_LED_O <= FAULT_I;
        end
    end

    // rising edges of alarm and fault are events
    assign ev_alarm = |((ALARM_LVL_I | test_lvl) & ~lvl_prev);
    assign ev_fault = FAULT_I & ~fault_prev;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            lvl_prev   <= 3'h0;
            fault_prev <= 1'b0;
        end
        else if (CE_I)
        begin
            lvl_prev   <= ALARM_LVL_I | test_lvl;
            fault_prev <= FAULT_I;
        end
    end

    // steady buzzer, a new event wins over silencing
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            BUZZER_O <= 1'b0;
        else if (CE_I)
        begin
            if (ev_alarm || ev_fault)
                BUZZER_O <= 1'b1;
            else if (clr)
                BUZZER_O <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            blink_cnt     <= '0;
            STANDBY_LED_O <= 1'b0;
        end
        else if (CE_I)
        begin
            if (!ctrl_stby)
            begin
                blink_cnt     <= '0;
                STANDBY_LED_O <= 1'b0;
            end
            else if (blink_cnt == BW'(BLINK_CYC - 1))
            begin
                blink_cnt     <= '0;
                STANDBY_LED_O <= !STANDBY_LED_O;
            end
            else
                blink_cnt <= blink_cnt + 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            flick_cnt    <= '0;
            DISP_BLANK_O <= 1'b0;
        end
        else if (CE_I)
        begin
            if (mode != MODE_TEST)
            begin
                flick_cnt    <= '0;
                DISP_BLANK_O <= 1'b0;
            end
            else if (flick_cnt == FW'(FLICK_CYC - 1))
            begin
                flick_cnt    <= '0;
                DISP_BLANK_O <= !DISP_BLANK_O;
            end
            else
                flick_cnt <= flick_cnt + 1'b1;
        end
    end

    // interrupt status, enable and write-one-to-clear
    assign irq_ev[`PNL_IRQ_KEY]   = |keys.press;
    assign irq_ev[`PNL_IRQ_ALARM] = ev_alarm;
    assign irq_ev[`PNL_IRQ_FAULT] = ev_fault;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            irq_stat <= 3'h0;
            irq_en   <= 3'h0;
            IRQ_O    <= 1'b0;
        end
        else if (CE_I)
        begin
            if (wr_en && AVS_ADDRESS_I == `PNL_OFS_ICLR)
                irq_stat <= (irq_stat & ~AVS_WRITEDATA_I[2:0]) | irq_ev;
            else
                irq_stat <= irq_stat | irq_ev;
            if (wr_en && AVS_ADDRESS_I == `PNL_OFS_IEN)
                irq_en <= AVS_WRITEDATA_I[2:0];
            IRQ_O <= |(irq_stat & irq_en);
        end
    end

    assign MODE_O       = mode;
    assign TEST_VALUE_O = test_val;

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    bus_answer_a: assert property (req && !ack && CE_I |=> !req || !CE_I || !AVS_WAITREQUEST_O)
        else $error("bus request not answered after one wait cycle");
    test_entry_a: assert property (
        mode == MODE_NORMAL && keys.press[`PNL_KEY_TEST] && !keys.press[`PNL_KEY_SEL] && CE_I
        |=> mode == MODE_TEST)
        else $error("test key did not enter self-test");
    test_exit_a: assert property (mode == MODE_TEST && clr && CE_I |=> mode == MODE_NORMAL)
        else $error("acknowledge did not end self-test");
    abort_set_a: assert property (
        mode == MODE_SETTING && clr && CE_I |=> mode == MODE_NORMAL && item == 2'h0)
        else $error("acknowledge did not abort setting entry");
    flicker_off_a: assert property (
        mode == MODE_NORMAL && $past(mode) == MODE_NORMAL && $past(CE_I) |-> !DISP_BLANK_O)
        else $error("display flickers outside self-test");
    lvl3_test_a: assert property (
        mode == MODE_TEST && test_val >= setv[2] && CE_I |=> ALARM_LED_O[2])
        else $error("level-3 lamp missing at test threshold");
    lvl1_live_a: assert property (
        ALARM_LVL_I[0] && CE_I ##1 CE_I && !clr |=> ALARM_LED_O[0] [*2])
        else $error("level-1 lamp not held after alarm");
    buzz_set_a: assert property ((ev_alarm || ev_fault) && CE_I |=> BUZZER_O)
        else $error("buzzer not sounding after event");
    buzz_ack_a: assert property (clr && !ev_alarm && !ev_fault && CE_I |=> !BUZZER_O)
        else $error("acknowledge did not silence buzzer");
    up_step_a: assert property (
        mode == MODE_SETTING && step[0] && !step[1] && !clr && !wr_en && CE_I
        && sel_val != 8'hFF && !keys.press[`PNL_KEY_SEL]
        |=> sel_val == $past(sel_val) + 8'h01)
        else $error("up step did not raise the value");
    standby_off_a: assert property (!ctrl_stby && CE_I |=> !STANDBY_LED_O)
        else $error("standby lamp lit outside standby");

    test_cov_c: cover property (mode == MODE_TEST ##1 step[2] ##1 mode == MODE_TEST);
    buzz_cov_c: cover property (BUZZER_O ##1 clr ##1 !BUZZER_O);
    set_cov_c: cover property (mode == MODE_SETTING && step[1]);
endmodule
`default_nettype wire

//--- tb/operator_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "panel_cfg.svh"
module operator_model
(
    // clock
    input  wire logic                  clk_i,
    // keys and reset contact, active low
    output var logic  [`PNL_NKEYS-1:0] keys_n_o
);
    initial keys_n_o = '1;

    // one press: key low for n cycles, then released and left to settle
    // key and contact
    task automatic press(input int k, input int n);
        @(posedge clk_i);
        keys_n_o[k] <= 1'b0;
        repeat (n) @(posedge clk_i);
        keys_n_o[k] <= 1'b1;
        repeat (12) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

//--- tb/tb_detector_front_panel_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "panel_cfg.svh"
module tb_detector_front_panel_control
    import panel_pkg::*;
;
    logic                  clk = 0, rst_n = 0, ce = 1, rd = 0, wr = 0, fault = 0;
    logic [7:0]            addr = '0, a, v;
    logic [31:0]           wd = '0, q, rdata;
    logic [2:0]            lvl = '0, alm, rl;
    logic [3:0]            be = 4'hF;
    logic [1:0]            mode;
    logic [7:0]            tval;
    logic [`PNL_NKEYS-1:0] keys_n;
    logic                  wait_o, irq, sby, trb, buz, blank, prev;
    int                    n_mismatch = 0, check_count = 0, tg;

    always #12.5 clk = ~clk;

    panel_ctrl #(.DEB_CYC(4), .HOLD_CYC(40), .RATE_CYC(8), .BLINK_CYC(16), .FLICK_CYC(8)) DUT (
        .REF_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_o), .IRQ_O(irq), .KEYS_N_I(keys_n),
        .ALARM_LVL_I(lvl), .FAULT_I(fault), .STANDBY_LED_O(sby), .ALARM_LED_O(alm),
        .TROUBLE_LED_O(trb), .BUZZER_O(buz), .DISP_BLANK_O(blank), .MODE_O(mode),
        .TEST_VALUE_O(tval));

    operator_model op (.clk_i(clk), .keys_n_o(keys_n));

    // lamps expected for a test value against thresholds 1, 2, 3
    function automatic logic [2:0] exp_led(input int t);
        return {t >= 3, t >= 2, t >= 1};
    endfunction

    // compare one result
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        addr <= ad;
        rd <= !w;
        wr <= w;
        wd <= d;
        do @(posedge clk); while (wait_o !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [7:0] ad, input logic [31:0] e);
        bus(1'b0, ad, '0);
        chk(nm, e, q);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // watchdog against a hung handshake
    initial
    begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        final_report();
    end

    // main sequence
    initial
    begin
        void'($urandom(19661));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rchk("ctrl", 8'h00, 32'h0);
        rchk("item0", 8'h10, 32'h14);
        rchk("item3", 8'h1C, 32'h05);
        rchk("ien", 8'h38, 32'h0);
        rchk("unmapped", 8'hFC, 32'h0);
        // setting entry, step up and down, then repeat on hold
        op.press(0, 12);
        chk("mode", MODE_SETTING, mode);
        op.press(0, 12);
        rchk("item step", 8'h04, 32'h5);
        a = 8'h14;
        v = 8'($urandom_range(200, 2));
        bus(1'b1, a, {24'h0, v});
        op.press(1, 12);
        rchk("up", a, v + 8'h01);
        op.press(2, 12);
        rchk("down", a, v);
        op.press(1, 120);
        bus(1'b0, a, '0);
        chk("repeat", 1, q > v + 2);
        op.press(4, 12);
        chk("abort", MODE_NORMAL, mode);
        // self-test with thresholds 1, 2, 3
        for (int i = 0; i < 3; i++) bus(1'b1, 8'h10 + 8'(4 * i), i + 1);
        op.press(3, 12);
        chk("test mode", MODE_TEST, mode);
        prev = blank;
        tg = 0;
        repeat (20) @(negedge clk) tg += int'(blank !== prev);
        chk("flicker", 1, tg > 0);
        for (int t = 1; t <= 3; t++)
        begin
            op.press(3, 12);
            chk("test value", t, tval);
            chk("test lamps", exp_led(t), alm);
            chk("test buzzer", 1, buz);
        end
        op.press(4, 12);
        chk("leave", {MODE_NORMAL, 8'h00, 3'b000, 1'b0}, {mode, tval, alm, buz});
        // write without byte lane 0 is refused
        be <= 4'hE;
        bus(1'b1, 8'h14, 32'h77);
        be <= 4'hF;
        rchk("refused", 8'h14, 32'h2);
        // live alarm with interrupt, cleared by the contact
        bus(1'b1, 8'h34, 32'h7);
        bus(1'b1, 8'h38, 32'h2);
        rl = 3'($urandom_range(7, 1));
        lvl <= rl;
        repeat (3) @(posedge clk);
        lvl <= 3'b000;
        repeat (3) @(posedge clk);
        chk("latched", {rl, 1'b1, 1'b1}, {alm, buz, irq});
        rchk("istat", 8'h30, 32'h2);
        bus(1'b1, 8'h34, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq clear", 0, irq);
        op.press(5, 12);
        chk("contact", 4'h0, {alm, buz});
        // fault sounds the buzzer
        fault <= 1'b1;
        repeat (3) @(posedge clk);
        chk("fault", 2'b11, {trb, buz});
        fault <= 1'b0;
        op.press(4, 12);
        chk("fault ack", 0, buz);
        // standby blink
        bus(1'b1, 8'h00, 32'h1);
        prev = sby;
        tg = 0;
        repeat (40) @(negedge clk)
        begin
            tg += int'(sby !== prev);
            prev = sby;
        end
        chk("blink", 1, tg >= 2 && tg <= 3);
        // clock enable low freezes the blink and the key filter
        @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        prev = sby;
        op.press(0, 12);
        chk("frozen", {prev, MODE_NORMAL}, {sby, mode});
        ce <= 1'b1;
        repeat (10) @(posedge clk);
        chk("thawed", MODE_NORMAL, mode);
        final_report();
    end
endmodule
`default_nettype wire
